// ===== hdl/rpc_pkg.sv
// Constants shared by the RF channel phase control block.
package rpc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus geometry.
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned NUM_QUAD  = 5;   // Observe plus four decouplers.
  localparam int unsigned NUM_FINE  = 4;   // Observe plus decouplers one to three.
  localparam int unsigned MULT_W    = 16;
  localparam int unsigned STEP_W    = 16;
  localparam int unsigned FINE_W    = 9;
  localparam int unsigned PROD_W    = MULT_W + STEP_W;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets; per-channel registers are one word apart.
  localparam logic [ADDR_W-1:0] REG_QUAD_BASE = 8'h00;  // Five words, 0x00 to 0x10.
  localparam logic [ADDR_W-1:0] REG_PULSE_ARG = 8'h14;
  localparam logic [ADDR_W-1:0] REG_MULT_BASE = 8'h20;  // Four words, 0x20 to 0x2c.
  localparam logic [ADDR_W-1:0] REG_STEP_BASE = 8'h30;  // Four words, 0x30 to 0x3c.
  localparam logic [ADDR_W-1:0] REG_STEP_SEL  = 8'h40;
  localparam logic [ADDR_W-1:0] REG_APPLIED   = 8'h44;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int unsigned QUAD_LSB     = 0;   // Quadrature code in quad registers.
  localparam int unsigned ARG_CH_LSB   = 0;   // Channel number in the pulse argument.
  localparam int unsigned ARG_QUAD_LSB = 4;   // Quadrature code in the pulse argument.
  localparam int unsigned SEL_CH_LSB   = 0;   // Channel selector in the step select word.
  localparam int unsigned SEL_STEP_LSB = 16;  // Step value in the step select word.

  ////////////////////////////////////////////////////////////////////////////////
  // Channel selector codes for the step select word.
  localparam logic [1:0] SEL_OBSERVE = 2'h0;
  localparam logic [1:0] SEL_DEC1    = 2'h1;
  localparam logic [1:0] SEL_DEC2    = 2'h2;
  localparam logic [1:0] SEL_DEC3    = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Resolution: fine units per ninety degrees, and the step in millidegrees.
  localparam int unsigned RES_MDEG_FINE     = 250;
  localparam int unsigned RES_MDEG_COARSE   = 1410;
  localparam logic [STEP_W-1:0] QUAD_UNITS_FINE   = 16'h0168;  // 360 steps of 0.25 deg.
  localparam logic [STEP_W-1:0] QUAD_UNITS_COARSE = 16'h0040;  // 64 steps of 1.41 deg.

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [1:0]        QUAD_RST = 2'h0;
  localparam logic [MULT_W-1:0] MULT_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Phase settling time after a quadrature change.
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned SETTLE_NS     = 200;
  localparam int unsigned SETTLE_CYC    = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage : rpc_pkg

// ===== hdl/rpc_fine_if.sv
// Carrier between the phase controller and one small-angle phase unit.
`timescale 1ns/10ps
`default_nettype none
interface rpc_fine_if #(
  parameter int unsigned MW = 16,
  parameter int unsigned SW = 16,
  parameter int unsigned FW = 9
);
  logic [MW-1:0] mult;
  logic [SW-1:0] step;
  logic [FW-1:0] fine;
  logic [1:0]    carry;

  modport calc (input mult, input step, output fine, output carry);
  modport ctrl (output mult, output step, input fine, input carry);
endinterface : rpc_fine_if
`default_nettype wire

// ===== hdl/rpc_fine_unit.sv
// Small-angle phase unit: splits multiplier times step into fine part and carry.
`timescale 1ns/10ps
`default_nettype none
module rpc_fine_unit
  import rpc_pkg::*;
#(
  parameter logic [STEP_W-1:0] QUAD_UNITS = QUAD_UNITS_FINE
) (
  rpc_fine_if.calc f
);

  logic [PROD_W-1:0] prod;
  logic [PROD_W-1:0] quot;
  logic [PROD_W-1:0] rem;

  // Product of multiplier and step, split at ninety degrees; whole quadrants wrap modulo four.
  assign prod    = PROD_W'(f.mult) * PROD_W'(f.step);
  assign quot    = prod / PROD_W'(QUAD_UNITS);
  assign rem     = prod % PROD_W'(QUAD_UNITS);
  assign f.fine  = rem[FINE_W-1:0];
  assign f.carry = quot[1:0];

endmodule : rpc_fine_unit
`default_nettype wire

// ===== hdl/rpc_phase_ctrl.sv
// RF channel phase control: quadrature phase for five channels, small-angle phase for four.
//
// Overview of operation
// - Every channel selects 0, 90, 180 or 270 degrees with no added delay.
// - Observe and four decouplers each hold their own writable quadrature setting.
// - A quadrature write without any pulse command is accepted.
// - Written phases take effect at the start of the next sequence event.
// - Decoupler modulation lines are XORed with the decoupler quadrature code.
// - Small-angle phase resolves 0.25 degree or 1.41 degree steps.
// - Small-angle phase acts on the transmitted signal, independent of receiver.
// - Small-angle settings are absolute; repeating a write changes nothing.
// - Each small-angle channel has its own step size, used only by it.
// - Small-angle phase equals multiplier times that channel's step size.
// - Step size starts at ninety degrees until first written.
// - Selector-addressed step write equals the fixed-channel step write.
// - Sub-ninety part goes to fine unit; whole quadrants carry to next selection.
// - Carryover works even with the default step size.
// - Quadrature writes and pulse arguments change only the ninety-degree portion.
// - Pulse phase arguments are in units of ninety degrees.
`timescale 1ns/10ps
`default_nettype none
module rpc_phase_ctrl
  import rpc_pkg::*;
#(
  parameter logic [STEP_W-1:0] QUAD_UNITS = QUAD_UNITS_FINE
) (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_sys_rst,
  input  wire logic [ADDR_W-1:0]          i_avs_address,
  input  wire logic                       i_avs_read,
  input  wire logic                       i_avs_write,
  input  wire logic [DATA_W-1:0]          i_avs_writedata,
  input  wire logic [3:0]                 i_avs_byteenable,
  output logic      [DATA_W-1:0]          o_avs_readdata,
  output logic                            o_avs_waitrequest,
  input  wire logic                       i_event_start,
  input  wire logic [2*(NUM_QUAD-1)-1:0]  i_dec_mod,
  output logic      [1:0]                 o_obs_quad,
  output logic      [2*(NUM_QUAD-1)-1:0]  o_dec_quad,
  output logic      [NUM_FINE*FINE_W-1:0] o_fine_phase,
  output logic                            o_quad_settling
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake: each request is answered after exactly one wait cycle.
  logic ack;
  logic req;
  logic take;

  assign req               = i_avs_read | i_avs_write;
  assign take              = req & ~ack;
  assign o_avs_waitrequest = req & ~ack;

  // The ack flop drops right after the accepting edge, so back-to-back requests each wait one cycle.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) ack <= 1'b0;
    else           ack <= take;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode. Partial-word writes are acknowledged but ignored.
  logic       wr_full;
  logic [5:0] word;
  logic       hit_quad;
  logic       hit_arg;
  logic       hit_mult;
  logic       hit_step;
  logic       hit_sel;
  logic       hit_appl;
  logic [2:0] quad_idx;
  logic [1:0] fine_idx;
  logic       wr_quad;
  logic       wr_arg;
  logic       wr_mult;
  logic       wr_step;
  logic       wr_sel;

  assign wr_full  = i_avs_write & (i_avs_byteenable == 4'hf) & take;
  assign word     = i_avs_address[7:2];
  assign hit_quad = (i_avs_address[1:0] == 2'h0) && (word < 6'(NUM_QUAD));
  assign hit_arg  = i_avs_address == REG_PULSE_ARG;
  assign hit_mult = (i_avs_address[7:4] == REG_MULT_BASE[7:4]) && (i_avs_address[1:0] == 2'h0);
  assign hit_step = (i_avs_address[7:4] == REG_STEP_BASE[7:4]) && (i_avs_address[1:0] == 2'h0);
  assign hit_sel  = i_avs_address == REG_STEP_SEL;
  assign hit_appl = i_avs_address == REG_APPLIED;
  assign quad_idx = word[2:0];
  assign fine_idx = word[1:0];
  assign wr_quad  = wr_full & hit_quad;
  assign wr_arg   = wr_full & hit_arg;
  assign wr_mult  = wr_full & hit_mult;
  assign wr_step  = wr_full & hit_step;
  assign wr_sel   = wr_full & hit_sel;

  // Pulse argument fields; channel codes above four are ignored.
  logic [2:0] arg_ch;
  logic [1:0] arg_quad;
  logic       arg_ok;
  logic [1:0] sel_ch;
  logic [STEP_W-1:0] sel_step;

  assign arg_ch   = i_avs_writedata[ARG_CH_LSB +: 3];
  assign arg_quad = i_avs_writedata[ARG_QUAD_LSB +: 2];
  assign arg_ok   = wr_arg & (arg_ch < 3'(NUM_QUAD));
  assign sel_ch   = i_avs_writedata[SEL_CH_LSB +: 2];
  assign sel_step = i_avs_writedata[SEL_STEP_LSB +: STEP_W];

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel quadrature state: pending code, pending flag and applied code.
  logic [1:0]  quad_pend [NUM_QUAD];
  logic        quad_due  [NUM_QUAD];
  logic [1:0]  quad_appl [NUM_QUAD];
  logic [1:0]  carry     [NUM_QUAD];
  logic [NUM_QUAD-1:0] quad_change;

  ////////////////////////////////////////////////////////////////////////////////
  // Small-angle state for observe and decouplers one to three.
  logic [MULT_W-1:0] mult      [NUM_FINE];
  logic              mult_due  [NUM_FINE];
  logic [STEP_W-1:0] step      [NUM_FINE];
  logic [FINE_W-1:0] fine_appl [NUM_FINE];
  logic [1:0]        carry_new [NUM_FINE];
  logic [FINE_W-1:0] fine_calc [NUM_FINE];

  genvar g;
  generate
    for (g = 0; g < NUM_QUAD; g++) begin : g_quad
      logic sel_q;
      logic sel_arg;
      logic fine_apply;
      logic [1:0] carry_in;

      assign sel_q   = wr_quad & (quad_idx == 3'(g));
      assign sel_arg = arg_ok & (arg_ch == 3'(g));

      // A write, with or without a pulse, only marks the code pending.
      always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
          quad_pend[g] <= QUAD_RST;
          quad_due[g]  <= 1'b0;
        end else if (sel_q) begin
          quad_pend[g] <= i_avs_writedata[QUAD_LSB +: 2];
          quad_due[g]  <= 1'b1;
        end else if (sel_arg) begin
          quad_pend[g] <= arg_quad;
          quad_due[g]  <= 1'b1;
        end else if (i_event_start) begin
          quad_due[g]  <= 1'b0;
        end
      end

      // Applied code changes only at an event start; the saved carry adds modulo four.
      always_ff @(posedge i_core_clk) begin
        if (i_sys_rst)                        quad_appl[g] <= QUAD_RST;
        else if (i_event_start && quad_due[g]) quad_appl[g] <= quad_pend[g] + carry[g];
      end

      assign quad_change[g] = i_event_start & quad_due[g];

      if (g < NUM_FINE) begin : g_has_fine
        assign fine_apply = i_event_start & mult_due[g];
        assign carry_in   = carry_new[g];
      end else begin : g_no_fine
        assign fine_apply = 1'b0;
        assign carry_in   = 2'h0;
      end

      // The carry is used by the next quadrature selection, then a new one may be saved.
      always_ff @(posedge i_core_clk) begin
        if (i_sys_rst)                        carry[g] <= 2'h0;
        else if (fine_apply)                  carry[g] <= carry_in;
        else if (quad_change[g])              carry[g] <= 2'h0;
      end
    end

    for (g = 0; g < NUM_FINE; g++) begin : g_fine
      rpc_fine_if #(.MW(MULT_W), .SW(STEP_W), .FW(FINE_W)) fif ();
      logic sel_m;
      logic sel_fixed;
      logic sel_by_ch;

      assign sel_m     = wr_mult & (fine_idx == 2'(g));
      assign sel_fixed = wr_step & (fine_idx == 2'(g));
      assign sel_by_ch = wr_sel & (sel_ch == 2'(g));
      assign fif.mult  = mult[g];
      assign fif.step  = step[g];
      assign fine_calc[g] = fif.fine;
      assign carry_new[g] = fif.carry;

      rpc_fine_unit #(.QUAD_UNITS(QUAD_UNITS)) u_fine (
        .f (fif.calc)
      );

      // Multiplier store; pending until the next event start.
      always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
          mult[g]     <= MULT_RST;
          mult_due[g] <= 1'b0;
        end else if (sel_m) begin
          mult[g]     <= i_avs_writedata[MULT_W-1:0];
          mult_due[g] <= 1'b1;
        end else if (i_event_start) begin
          mult_due[g] <= 1'b0;
        end
      end

      // Both step write paths land in the same register.
      always_ff @(posedge i_core_clk) begin
        if (i_sys_rst)      step[g] <= QUAD_UNITS;
        else if (sel_fixed) step[g] <= i_avs_writedata[STEP_W-1:0];
        else if (sel_by_ch) step[g] <= sel_step;
      end

      // Fine phase is absolute: it is recomputed, never accumulated.
      always_ff @(posedge i_core_clk) begin
        if (i_sys_rst)                         fine_appl[g] <= '0;
        else if (i_event_start && mult_due[g]) fine_appl[g] <= fine_calc[g];
      end

      // No receiver phase enters the fine output path.
      assign o_fine_phase[g*FINE_W +: FINE_W] = fine_appl[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs. Decoupler codes are XORed with modulation lines and registered.
  logic [2*(NUM_QUAD-1)-1:0] dec_code;
  logic [2*(NUM_QUAD-1)-1:0] next_dec_quad;

  generate
    for (g = 1; g < NUM_QUAD; g++) begin : g_dec_out
      assign dec_code[2*(g-1) +: 2] = quad_appl[g];
    end
  endgenerate
  assign next_dec_quad = dec_code ^ i_dec_mod;

  // Registered outputs add one cycle; no programmable delay is ever inserted.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_obs_quad <= QUAD_RST;
      o_dec_quad <= '0;
    end else begin
      o_obs_quad <= quad_appl[0];
      o_dec_quad <= next_dec_quad;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Settling indicator: high for the settle time after any quadrature change.
  localparam int unsigned SETTLE_W = $clog2(SETTLE_CYC + 1);
  logic [SETTLE_W-1:0] settle_cnt;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst)            settle_cnt <= '0;
    else if (|quad_change)    settle_cnt <= SETTLE_W'(SETTLE_CYC);
    else if (settle_cnt != 0) settle_cnt <= settle_cnt - SETTLE_W'(1);
  end
  assign o_quad_settling = settle_cnt != 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux. Unmapped addresses read zero.
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] appl_word;

  assign appl_word = {14'h0, carry[3], carry[2], carry[1], carry[0],
                      quad_appl[4], quad_appl[3], quad_appl[2], quad_appl[1], quad_appl[0]};
  assign rd_mux = hit_quad ? DATA_W'(quad_pend[quad_idx]) :
                  hit_mult ? DATA_W'(mult[fine_idx]) :
                  hit_step ? DATA_W'(step[fine_idx]) :
                  hit_appl ? appl_word : '0;

  // Read data loads at the edge ending the wait cycle and stands while waitrequest is low.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst)              o_avs_readdata <= '0;
    else if (take & i_avs_read) o_avs_readdata <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  property p_one_wait;
    req && !ack |-> o_avs_waitrequest ##1 (!o_avs_waitrequest || !req);
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("Bus answer not after one wait.");

  property p_quad_hold;
    !i_event_start |=> $stable(quad_appl[0]) && $stable(quad_appl[1]);
  endproperty
  a_quad_hold: assert property (p_quad_hold) else $error("Quad phase moved mid event.");

  property p_quad_apply;
    i_event_start && quad_due[0] |=> quad_appl[0] == $past(quad_pend[0]) + $past(carry[0]);
  endproperty
  a_quad_apply: assert property (p_quad_apply) else $error("Quad code or carry wrong.");

  property p_obs_out;
    1 |=> o_obs_quad == $past(quad_appl[0]);
  endproperty
  a_obs_out: assert property (p_obs_out) else $error("Observe quad output lags.");

  property p_dec_xor;
    1 |=> o_dec_quad == ($past(dec_code) ^ $past(i_dec_mod));
  endproperty
  a_dec_xor: assert property (p_dec_xor) else $error("Decoupler XOR wrong.");

  property p_fine_calc;
    i_event_start && mult_due[2] |=>
      fine_appl[2] == FINE_W'((PROD_W'($past(mult[2])) * PROD_W'($past(step[2]))) % PROD_W'(QUAD_UNITS));
  endproperty
  a_fine_calc: assert property (p_fine_calc) else $error("Fine phase not mult times step.");

  // Multiplier writes legitimately move the fine phase at the next event, so they are left out.
  logic sel_any_mult;
  assign sel_any_mult = wr_mult;

  property p_quad_keeps_fine;
    (wr_quad || wr_arg) && !sel_any_mult |=> $stable(fine_appl[2]) || $past(i_event_start && mult_due[2]);
  endproperty
  a_quad_keeps_fine: assert property (p_quad_keeps_fine) else $error("Quad write moved fine phase.");

  property p_step_same;
    wr_sel && sel_ch == SEL_DEC2 |=> step[2] == $past(sel_step);
  endproperty
  a_step_same: assert property (p_step_same) else $error("Selector step write lost.");

  property p_settle;
    |quad_change |=> o_quad_settling [*8];
  endproperty
  a_settle: assert property (p_settle) else $error("Settling flag dropped early.");

  c_quad_event: cover property (wr_quad ##[1:20] quad_change[0]);
  c_carry_used: cover property (quad_change[2] && carry[2] != 2'h0);
  c_partial:    cover property (i_avs_write && take && i_avs_byteenable != 4'hf);
  c_sel_write:  cover property (wr_sel && sel_ch == SEL_DEC3);
  c_dec_mod:    cover property (|i_dec_mod && |dec_code);

endmodule : rpc_phase_ctrl
`default_nettype wire

// ===== dv/rpc_seq_model.sv
// Sequencer stand-in that issues event starts and drives the decoupler modulation lines.
`timescale 1ns/10ps
`default_nettype none
module rpc_seq_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_fire,
  input  wire logic       i_settling,
  input  wire logic [7:0] i_mod,
  output logic            o_event_start,
  output logic      [7:0] o_dec_mod
);
  logic fire_q;
  logic armed;

  ////////////////////////////////////////////////////////////////////////////////
  // One event per request, held back while the phase is still settling.
  always_ff @(posedge i_core_clk) begin
    fire_q        <= i_fire;
    armed         <= !i_sys_rst && ((i_fire && !fire_q) || (armed && i_settling));
    o_event_start <= !i_sys_rst && armed && !i_settling;
  end

  // The modulation pattern is a level chosen by the bench, passed straight on.
  assign o_dec_mod = i_mod;
endmodule : rpc_seq_model
`default_nettype wire

// ===== dv/test_rpc_phase_ctrl.sv
// Self-checking bench for the RF channel phase control block.
`timescale 1ns/10ps
`default_nettype none
module test_rpc_phase_ctrl;
  import rpc_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] obs; logic [7:0] dec;} rpc_row_s;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0]  be = 4'hf;
  logic [31:0] rdata;
  logic        wreq;
  logic        fire = 1'b0;
  logic [7:0]  mod = 8'h00;
  logic        ev_start;
  logic [7:0]  dec_mod;
  logic [1:0]  obs;
  logic [7:0]  dec;
  logic [35:0] fine;
  logic        settling;
  int          errors = 0;
  int          checks = 0;
  int          cyc = 0;
  rpc_row_s    rows [7] = '{'{8'h00, 32'h1, 2'h1, 8'h00}, '{8'h04, 32'h2, 2'h1, 8'h02},
                            '{8'h08, 32'h3, 2'h1, 8'h0e}, '{8'h0c, 32'h1, 2'h1, 8'h1e},
                            '{8'h10, 32'h2, 2'h1, 8'h9e}, '{8'h14, 32'h30, 2'h3, 8'h9e},
                            '{8'h14, 32'h04, 2'h3, 8'h1e}};

  always #2 clk = ~clk;

  rpc_phase_ctrl i_rpc_phase_ctrl (.i_core_clk(clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_event_start(ev_start), .i_dec_mod(dec_mod), .o_obs_quad(obs),
    .o_dec_quad(dec), .o_fine_phase(fine), .o_quad_settling(settling));

  rpc_seq_model i_rpc_seq_model (.i_core_clk(clk), .i_sys_rst(rst), .i_fire(fire), .i_settling(settling),
    .i_mod(mod), .o_event_start(ev_start), .o_dec_mod(dec_mod));

  ////////////////////////////////////////////////////////////////////////////////
  // Closing report, shared by the main sequence and the hang guard.
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input string s, input logic [35:0] e, input logic [35:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  // One Avalon access; the request stands until the rising edge at which waitrequest is seen low.
  // Only the hang guard ends a wait, so the master assumes no fixed answer time.
  task automatic bus(input logic r, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    rd  <= r;
    wr  <= !r;
    wd  <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask : wr_reg

  task automatic rd_chk(input string s, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b1, a, 32'h0, q);
    chk(s, {4'h0, e}, {4'h0, q});
  endtask : rd_chk

  // Asks the sequencer for one event, then lets the registered outputs land.
  task automatic ev;
    fire <= 1'b1;
    do @(posedge clk); while (ev_start !== 1'b1);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : ev

  // Hang guard: the whole run needs a few thousand cycles at most.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: table of quadrature writes, then the hand-written cases.
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_chk("step_obs_rst", 8'h30, 32'h168);
    rd_chk("unmapped", 8'h80, 32'h0);
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      ev();
      chk("obs_quad", {34'h0, rows[i].obs}, {34'h0, obs});
      chk("dec_quad", {28'h0, rows[i].dec}, {28'h0, dec});
    end
    wr_reg(8'h00, 32'h0);
    repeat (4) @(posedge clk);
    chk("obs_held", 36'h3, {34'h0, obs});
    ev();
    chk("obs_next_event", 36'h0, {34'h0, obs});
    chk("settling", 36'h1, {35'h0, settling});
    be <= 4'h3;
    wr_reg(8'h00, 32'h2);
    be <= 4'hf;
    ev();
    chk("obs_partial", 36'h0, {34'h0, obs});
    // Default step of ninety degrees: five steps leave fine zero and one quadrant carried.
    wr_reg(8'h20, 32'h5);
    ev();
    chk("fine_obs", 36'h0, {27'h0, fine[8:0]});
    wr_reg(8'h00, 32'h2);
    ev();
    chk("obs_carry", 36'h3, {34'h0, obs});
    wr_reg(8'h20, 32'h6);
    wr_reg(8'h20, 32'h6);
    ev();
    wr_reg(8'h00, 32'h2);
    ev();
    chk("obs_absolute", 36'h0, {34'h0, obs});
    // Selector write of step 100 to the second decoupler; seven steps give 340 and one carry.
    wr_reg(8'h40, 32'h0064_0002);
    rd_chk("step_dec2", 8'h38, 32'h64);
    rd_chk("step_obs", 8'h30, 32'h168);
    wr_reg(8'h28, 32'h7);
    ev();
    chk("fine_dec2", 36'h154, {27'h0, fine[26:18]});
    wr_reg(8'h08, 32'h0);
    ev();
    chk("fine_kept", 36'h154, {27'h0, fine[26:18]});
    chk("dec_carry", 36'h16, {28'h0, dec});
    rd_chk("applied", 8'h44, 32'h58);
    wr_reg(8'h28, 32'h0);
    ev();
    chk("fine_clear", 36'h0, {27'h0, fine[26:18]});
    mod <= 8'hff;
    repeat (3) @(posedge clk);
    chk("dec_xor", 36'he9, {28'h0, dec});
    mod <= 8'h00;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("rst_fine", 36'h0, fine);
    chk("rst_obs", 36'h0, {34'h0, obs});
    chk("rst_dec", 36'h0, {28'h0, dec});
    chk("rst_settling", 36'h0, {35'h0, settling});
    rd_chk("step_dec2_rst", 8'h38, 32'h168);
    stop_test();
  end
endmodule : test_rpc_phase_ctrl
`default_nettype wire
